/* rtl/rfct_pkg.sv */
// Constants and types shared by the countdown timer pair.
// Assumes a 100 MHz pclk and an APB master with 8-bit byte addresses.
package rfct_pkg;

	// Bus geometry
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int IDX_W  = 6;
	localparam int CNT_W  = 16;
	localparam int NUM_TIMERS = 2;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_GLOBAL_CTRL   = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_A_CONTROL     = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_A_RELOAD_HIGH = 6'h10;
	localparam logic [IDX_W-1:0] IDX_A_RELOAD_LOW  = 6'h11;
	localparam logic [IDX_W-1:0] IDX_A_COUNT_HIGH  = 6'h12;
	localparam logic [IDX_W-1:0] IDX_A_COUNT_LOW   = 6'h13;
	localparam logic [IDX_W-1:0] IDX_B_CONTROL     = 6'h14;
	localparam logic [IDX_W-1:0] IDX_B_RELOAD_HIGH = 6'h15;
	localparam logic [IDX_W-1:0] IDX_B_RELOAD_LOW  = 6'h16;
	localparam logic [IDX_W-1:0] IDX_B_COUNT_HIGH  = 6'h17;
	localparam logic [IDX_W-1:0] IDX_B_COUNT_LOW   = 6'h18;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 6'h1F;

	// Field layout of the global control byte
	localparam int GC_MASK_LSB = 0;
	localparam int GC_RUN_LSB  = 4;

	// Control byte: bits 6 and 2 are reserved
	localparam logic [7:0] CTRL_WMASK = 8'hBB;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

	// Start modes
	localparam logic [1:0] START_HOST     = 2'b00;
	localparam logic [1:0] START_TX_END   = 2'b01;
	localparam logic [1:0] START_TRIM_NOU = 2'b10;
	localparam logic [1:0] START_TRIM_UFL = 2'b11;

	// Clock selects
	localparam logic [1:0] CLK_FAST  = 2'b00;
	localparam logic [1:0] CLK_SLOW  = 2'b01;
	localparam logic [1:0] CLK_CAS10 = 2'b10;
	localparam logic [1:0] CLK_CAS11 = 2'b11;

	// Timing: reference rate derived from pclk by a fractional accumulator
	localparam int PCLK_KHZ = 100000;
	localparam int REF_KHZ  = 13560;
	localparam int ACC_W    = 17;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_KHZ);
	localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(PCLK_KHZ);
	localparam logic [ACC_W-1:0] ACC_ZERO = 17'h00000;
	// 13.56 MHz / 64 = 211.875 kHz
	localparam int SLOW_DIV_W = 6;
	localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = 6'h3F;
	localparam logic [SLOW_DIV_W-1:0] SLOW_ZERO = 6'h00;

	typedef struct packed {
		logic       stop_on_receive;
		logic       rsv6;
		logic [1:0] start_mode;
		logic       auto_restart;
		logic       rsv2;
		logic [1:0] clock_select;
	} rfct_ctrl_t;

	typedef struct packed {
		logic             tick;
		logic             start;
		logic             stop;
		logic             trim_no_underflow;
		logic             auto_restart;
		logic [CNT_W-1:0] reload;
	} rfct_cmd_t;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             running;
		logic             underflow;
	} rfct_core_state_t;

endpackage : rfct_pkg

/* rtl/rfct_down_counter.sv */
// One 16-bit countdown timer with reload, auto-restart and trim handling.
// Assumes start/stop/tick are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
module rfct_down_counter
	import rfct_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire rfct_cmd_t        cmd,
	output rfct_core_state_t      state
);

	rfct_core_state_t s_q;
	rfct_core_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.underflow = 1'b0;
		if (cmd.start)
		begin
			s_d.count   = cmd.reload;
			s_d.running = 1'b1;
		end
		else if (cmd.stop)
			s_d.running = 1'b0;
		else if (s_q.running && cmd.tick)
		begin
			if (s_q.count != CNT_ZERO)
				s_d.count = s_q.count - CNT_ONE;
			else if (!cmd.trim_no_underflow)
			begin
				// Trimming without underflow holds at zero until the next edge
				s_d.underflow = 1'b1;
				if (cmd.auto_restart)
					s_d.count = cmd.reload;
				else
					s_d.running = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign state = s_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_plain_tick;
		s_q.running && cmd.tick && !cmd.start && !cmd.stop;
	endsequence

	a_count_decrement: assert property (
		s_plain_tick and (s_q.count != CNT_ZERO)
		|=> s_q.count == $past(s_q.count) - CNT_ONE && s_q.running)
		else $error("count did not decrement by one");

	a_auto_reload: assert property (
		s_plain_tick and (s_q.count == CNT_ZERO) and cmd.auto_restart
		and !cmd.trim_no_underflow
		|=> s_q.running && s_q.count == $past(cmd.reload) && s_q.underflow)
		else $error("auto restart did not reload");

	a_stop_at_zero: assert property (
		s_plain_tick and (s_q.count == CNT_ZERO) and !cmd.auto_restart
		and !cmd.trim_no_underflow
		|=> !s_q.running && s_q.underflow ##1 !s_q.underflow)
		else $error("timer did not stop at zero");

	a_start_loads: assert property (
		cmd.start |=> s_q.running && s_q.count == $past(cmd.reload))
		else $error("start did not load reload value");

	a_count_holds: assert property (
		!cmd.start && !(s_q.running && cmd.tick) |=> $stable(s_q.count))
		else $error("count changed without tick or start");

endmodule : rfct_down_counter

/* rtl/rfct_timers.sv */
// Two cascadable countdown timers with their APB register file.
// Assumes APB master on pclk; event inputs are one-cycle pulses on pclk.
// What this block does
// - First timer loads reload bytes on start
// - Reload writes only matter at next start or auto-restart reload
// - Live count readable as high, low bytes
// - Stop-on-receive halts after first four bits
// - Stop-on-receive ignored in trimming modes
// - Start mode 00: host start only
// - Start mode 01: start at transmit end
// - Mode 10: trimming, no underflow, edge start/stop
// - Mode 11: trimming with underflow, edge start/stop
// - Auto-restart reloads at zero, keeps counting
// - Without auto-restart stop at zero
// - Underflow sets the sticky interrupt flag
// - Clock select 00 fast, 01 slow
// - Second timer cascades: 10 first, 11 third
// - Second timer loads its own reload bytes
// - First timer cascades: 10 third, 11 second
// - Global run bits change only where masked
// - Running status bit, masked start/stop
`timescale 1ns/1ps
module rfct_timers
	import rfct_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [APB_DW-1:0] pwdata,
	output logic      [APB_DW-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              tx_done,
	input  wire logic              rx_first_bits,
	input  wire logic              trim_ref,
	input  wire logic              third_timer_underflow,
	output logic                   timer_a_running,
	output logic                   timer_b_running,
	output logic                   timer_b_irq_flag
);

	typedef struct packed {
		logic [ACC_W-1:0]                 acc;
		logic [SLOW_DIV_W-1:0]            slow_cnt;
		logic                             fast_tick;
		logic                             slow_tick;
		logic                             trim_ref_prev;
		rfct_ctrl_t [NUM_TIMERS-1:0]      ctrl;
		logic [NUM_TIMERS-1:0][CNT_W-1:0] reload;
		logic [NUM_TIMERS-1:0]            irq;
		logic [APB_DW-1:0]                rdata;
		logic                             err;
	} rfct_state_t;

	rfct_state_t                      s_q;
	rfct_state_t                      s_d;
	rfct_cmd_t [NUM_TIMERS-1:0]       cmd;
	rfct_core_state_t [NUM_TIMERS-1:0] core;
	logic [NUM_TIMERS-1:0]            host_start;
	logic [NUM_TIMERS-1:0]            host_stop;
	logic                             setup_ph;
	logic                             write_ph;
	logic                             dec_ok;
	logic [IDX_W-1:0]                 dec_idx;
	logic                             trim_edge;
	logic                             irq_clr_b;

	// Byte address to index; misaligned or unknown is unmapped
	function automatic logic [IDX_W:0] decode(input logic [APB_AW-1:0] addr);
		logic [IDX_W-1:0] idx;
		logic             ok;
		idx = addr[APB_AW-1:2];
		ok  = (addr[1:0] == 2'b00) &&
			((idx >= IDX_GLOBAL_CTRL && idx <= IDX_B_COUNT_LOW) || idx == IDX_IRQ_STATUS);
		return {ok, idx};
	endfunction : decode

	// Count clock selection shared by both timers
	function automatic logic sel_tick(
		input logic [1:0] sel,
		input logic       fast,
		input logic       slow,
		input logic       cas10,
		input logic       cas11
	);
		logic t;
		unique case (sel)
			CLK_FAST:  t = fast;
			CLK_SLOW:  t = slow;
			CLK_CAS10: t = cas10;
			CLK_CAS11: t = cas11;
		endcase
		return t;
	endfunction : sel_tick

	assign setup_ph  = psel && !penable;
	assign write_ph  = psel && penable && pwrite;
	assign {dec_ok, dec_idx} = decode(paddr);
	assign trim_edge = trim_ref && !s_q.trim_ref_prev;
	assign irq_clr_b = write_ph && dec_ok && dec_idx == IDX_IRQ_STATUS && pwdata[1];

	// Masked global write: mask bit picks which run bit the write touches
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++)
		begin : g_timer
			logic mode_trim;
			logic auto_start;
			logic auto_stop;
			logic hit_gc;

			assign hit_gc        = write_ph && dec_ok && dec_idx == IDX_GLOBAL_CTRL;
			assign host_start[gi] = hit_gc && pwdata[GC_MASK_LSB+gi] &&
				pwdata[GC_RUN_LSB+gi];
			assign host_stop[gi]  = hit_gc && pwdata[GC_MASK_LSB+gi] &&
				!pwdata[GC_RUN_LSB+gi];
			assign mode_trim = s_q.ctrl[gi].start_mode[1];
			// Mode 00 has no automatic start source at all
			assign auto_start =
				(s_q.ctrl[gi].start_mode == START_TX_END && tx_done) ||
				(mode_trim && trim_edge && !core[gi].running);
			assign auto_stop =
				(s_q.ctrl[gi].stop_on_receive && !mode_trim && rx_first_bits) ||
				(mode_trim && trim_edge && core[gi].running);

			// Host command beats any automatic event in the same cycle
			assign cmd[gi].start = host_start[gi] || (auto_start && !host_stop[gi]);
			assign cmd[gi].stop  = host_stop[gi] || (auto_stop && !host_start[gi]);
			assign cmd[gi].trim_no_underflow =
				s_q.ctrl[gi].start_mode == START_TRIM_NOU;
			assign cmd[gi].auto_restart = s_q.ctrl[gi].auto_restart;
			assign cmd[gi].reload       = s_q.reload[gi];

			rfct_down_counter u_counter (
				.pclk    (pclk),
				.presetn (presetn),
				.cmd     (cmd[gi]),
				.state   (core[gi])
			);
		end
	endgenerate

	// Cascade: underflow pulses are registered, so no combinational loop
	assign cmd[0].tick = sel_tick(s_q.ctrl[0].clock_select, s_q.fast_tick, s_q.slow_tick,
		third_timer_underflow, core[1].underflow);
	assign cmd[1].tick = sel_tick(s_q.ctrl[1].clock_select, s_q.fast_tick, s_q.slow_tick,
		core[0].underflow, third_timer_underflow);

	always_comb
	begin
		logic [ACC_W-1:0] acc_sum;
		acc_sum = s_q.acc + ACC_STEP;
		s_d = s_q;
		s_d.trim_ref_prev = trim_ref;

		// Fractional divider: average 13.56 MHz from 100 MHz, jitter one pclk
		s_d.fast_tick = 1'b0;
		s_d.slow_tick = 1'b0;
		if (acc_sum >= ACC_MOD)
		begin
			s_d.acc       = acc_sum - ACC_MOD;
			s_d.fast_tick = 1'b1;
			s_d.slow_cnt  = s_q.slow_cnt + 6'h01;
			s_d.slow_tick = (s_q.slow_cnt == SLOW_LAST);
		end
		else
			s_d.acc = acc_sum;

		// Read data captured in setup so the access phase answers from flops
		if (setup_ph)
		begin
			s_d.err   = !dec_ok;
			s_d.rdata = '0;
			if (dec_ok && !pwrite)
			begin
				unique case (dec_idx)
					IDX_GLOBAL_CTRL:
						s_d.rdata[GC_RUN_LSB +: NUM_TIMERS] =
							{core[1].running, core[0].running};
					IDX_A_CONTROL:     s_d.rdata[7:0] = s_q.ctrl[0];
					IDX_A_RELOAD_HIGH: s_d.rdata[7:0] = s_q.reload[0][15:8];
					IDX_A_RELOAD_LOW:  s_d.rdata[7:0] = s_q.reload[0][7:0];
					IDX_A_COUNT_HIGH:  s_d.rdata[7:0] = core[0].count[15:8];
					IDX_A_COUNT_LOW:   s_d.rdata[7:0] = core[0].count[7:0];
					IDX_B_CONTROL:     s_d.rdata[7:0] = s_q.ctrl[1] & CTRL_WMASK;
					IDX_B_RELOAD_HIGH: s_d.rdata[7:0] = s_q.reload[1][15:8];
					IDX_B_RELOAD_LOW:  s_d.rdata[7:0] = s_q.reload[1][7:0];
					IDX_B_COUNT_HIGH:  s_d.rdata[7:0] = core[1].count[15:8];
					IDX_B_COUNT_LOW:   s_d.rdata[7:0] = core[1].count[7:0];
					IDX_IRQ_STATUS:    s_d.rdata[NUM_TIMERS-1:0] = s_q.irq;
					default:           s_d.rdata = '0;
				endcase
			end
		end

		// Writes land only on the access edge; reload bytes never touch the count
		if (write_ph && dec_ok)
		begin
			unique case (dec_idx)
				IDX_A_CONTROL:     s_d.ctrl[0] = pwdata[7:0] & CTRL_WMASK;
				IDX_A_RELOAD_HIGH: s_d.reload[0][15:8] = pwdata[7:0];
				IDX_A_RELOAD_LOW:  s_d.reload[0][7:0]  = pwdata[7:0];
				IDX_B_CONTROL:     s_d.ctrl[1] = pwdata[7:0] & CTRL_WMASK;
				IDX_B_RELOAD_HIGH: s_d.reload[1][15:8] = pwdata[7:0];
				IDX_B_RELOAD_LOW:  s_d.reload[1][7:0]  = pwdata[7:0];
				IDX_IRQ_STATUS:    s_d.irq = s_q.irq & ~pwdata[NUM_TIMERS-1:0];
				default:           s_d.irq = s_d.irq;
			endcase
		end

		// Set after clear so a same-cycle underflow is never lost
		for (int i = 0; i < NUM_TIMERS; i++)
			if (core[i].underflow)
				s_d.irq[i] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q          <= '0;
			s_q.ctrl[0]  <= CTRL_RESET;
			s_q.ctrl[1]  <= CTRL_RESET;
		end
		else
			s_q <= s_d;
	end

	// Zero wait states; the host must not read counts mid-reception
	assign pready           = 1'b1;
	assign prdata           = s_q.rdata;
	assign pslverr          = psel && penable && s_q.err;
	assign timer_a_running  = core[0].running;
	assign timer_b_running  = core[1].running;
	assign timer_b_irq_flag = s_q.irq[1];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_b_underflow;
		core[1].underflow;
	endsequence

	// A clear right after the set may end the flag early
	sequence s_b_flag_held;
		s_q.irq[1] ##1 (s_q.irq[1] || $past(irq_clr_b));
	endsequence

	a_irq_flag_set: assert property (
		s_b_underflow |=> s_b_flag_held)
		else $error("underflow did not set sticky flag");

	a_stop_receive: assert property (
		core[1].running && rx_first_bits && s_q.ctrl[1].stop_on_receive &&
		!s_q.ctrl[1].start_mode[1] && !host_start[1] && !cmd[1].start
		|=> !core[1].running)
		else $error("stop on receive did not halt timer");

	a_trim_ignores_rx: assert property (
		core[1].running && rx_first_bits && s_q.ctrl[1].start_mode[1] &&
		!trim_edge && !host_stop[1] && !(cmd[1].tick && core[1].count == CNT_ZERO)
		|=> core[1].running)
		else $error("receive stopped a trimming timer");

	a_host_only_start: assert property (
		!core[1].running && s_q.ctrl[1].start_mode == START_HOST && !host_start[1]
		|=> !core[1].running)
		else $error("timer started by itself in host mode");

	a_tx_end_start: assert property (
		s_q.ctrl[1].start_mode == START_TX_END && tx_done && !host_stop[1]
		|=> core[1].running ##1 (core[1].running || $past(cmd[1].stop) ||
			$past(cmd[1].tick)))
		else $error("transmit end did not start timer");

	a_cascade_b: assert property (
		s_q.ctrl[1].clock_select == CLK_CAS10 |-> cmd[1].tick == core[0].underflow)
		else $error("second timer not clocked by first underflow");

	a_cascade_a: assert property (
		s_q.ctrl[0].clock_select == CLK_CAS11 |-> cmd[0].tick == core[1].underflow)
		else $error("first timer not clocked by second underflow");

	a_mask_blocks: assert property (
		write_ph && dec_ok && dec_idx == IDX_GLOBAL_CTRL && !pwdata[GC_MASK_LSB]
		|-> !host_start[0] && !host_stop[0])
		else $error("unmasked run bit was changed");

	a_reserved_zero: assert property (
		psel && penable && !pwrite && paddr[APB_AW-1:2] == IDX_B_CONTROL
		|-> prdata[6] == 1'b0 && prdata[2] == 1'b0)
		else $error("reserved control bits read nonzero");

	a_count_read: assert property (
		setup_ph && !pwrite && dec_ok && dec_idx == IDX_A_COUNT_LOW
		|=> prdata[7:0] == $past(core[0].count[7:0]))
		else $error("count low byte read wrong");

	a_clock_fast: assert property (
		s_q.ctrl[1].clock_select == CLK_FAST |-> cmd[1].tick == s_q.fast_tick)
		else $error("fast select did not pass fast tick");

	a_clock_slow: assert property (
		s_q.ctrl[1].clock_select == CLK_SLOW |-> cmd[1].tick == s_q.slow_tick)
		else $error("slow select did not pass slow tick");

	a_slow_aligned: assert property (
		s_q.slow_tick |-> s_q.fast_tick)
		else $error("slow tick off the fast tick grid");

	a_cascade_third: assert property (
		s_q.ctrl[1].clock_select == CLK_CAS11 |-> cmd[1].tick == third_timer_underflow)
		else $error("second timer not clocked by third underflow");

	a_cascade_ext_a: assert property (
		s_q.ctrl[0].clock_select == CLK_CAS10 |-> cmd[0].tick == third_timer_underflow)
		else $error("first timer not clocked by third underflow");

	a_trim_no_underflow: assert property (
		s_q.ctrl[1].start_mode == START_TRIM_NOU |=> !core[1].underflow)
		else $error("underflow in trimming without underflow");

	a_trim_edge_start: assert property (
		s_q.ctrl[1].start_mode == START_TRIM_UFL && trim_edge && !core[1].running &&
		!host_stop[1]
		|=> core[1].running)
		else $error("trim edge did not start timer");

	a_host_start_b: assert property (
		host_start[1] |=> core[1].running && core[1].count == $past(s_q.reload[1]))
		else $error("second timer did not load its reload value");

	a_run_status: assert property (
		setup_ph && !pwrite && dec_ok && dec_idx == IDX_GLOBAL_CTRL
		|=> prdata[GC_RUN_LSB] == $past(core[0].running) &&
			prdata[GC_RUN_LSB+1] == $past(core[1].running))
		else $error("running status read wrong");

	a_reload_no_touch: assert property (
		write_ph && dec_ok && dec_idx == IDX_A_RELOAD_LOW && !cmd[0].start && !cmd[0].tick
		|=> $stable(core[0].count))
		else $error("reload write changed a running count");

	a_irq_clear: assert property (
		irq_clr_b && !core[1].underflow |=> !s_q.irq[1])
		else $error("sticky flag not cleared by write");

endmodule : rfct_timers

/* verif/rfct_timers_test.sv */
// Self-checking bench for the countdown timer pair.
// Drives APB and the event inputs directly; no far-side model needed.
`timescale 1ns/1ps
module rfct_timers_test
	import rfct_pkg::*;
;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata;
	logic [APB_DW-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              tx_done;
	logic              rx_first_bits;
	logic              trim_ref;
	logic              third_timer_underflow;
	logic              timer_a_running;
	logic              timer_b_running;
	logic              timer_b_irq_flag;
	int                miscompares;
	int                checks;
	int                seed;
	int                i;
	logic [31:0]       rdv;
	logic              errv;
	logic [7:0]        wv;
	logic [7:0]        a_hi;
	logic [15:0]       cnt;

	rfct_timers i_dut (
		.pclk                  (pclk),
		.presetn               (presetn),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.tx_done               (tx_done),
		.rx_first_bits         (rx_first_bits),
		.trim_ref              (trim_ref),
		.third_timer_underflow (third_timer_underflow),
		.timer_a_running       (timer_a_running),
		.timer_b_running       (timer_b_running),
		.timer_b_irq_flag      (timer_b_irq_flag)
	);

	always #5 pclk = ~pclk;

	// Worst case: fast tick at most 8 pclk apart, slow one 64 fast ticks
	function automatic int tbound(input logic [15:0] rl, input logic slow);
		return (int'(rl) + 2) * (slow ? 64 : 1) * 8 + 20;
	endfunction : tbound

	function automatic logic [31:0] cexp(input logic [7:0] d);
		return {24'h000000, d & CTRL_WMASK};
	endfunction : cexp

	task give_verdict;
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task fail_to(input string nm);
		miscompares++;
		$display("Error %s expected done seen timeout", nm);
		give_verdict();
	endtask : fail_to

	// Answer taken at the rising edge that samples pready high
	task apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
		input logic [1:0] lo);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, lo};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 50)
				fail_to("pready");
			@(posedge pclk);
		end
		rdv     = prdata;
		errv    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Return after the access edge so outputs it launched are settled
		#1;
	endtask : apb

	task wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 2'b00);
	endtask : wr

	task rd(input logic [IDX_W-1:0] idx);
		apb(1'b0, idx, 8'h00, 2'b00);
	endtask : rd

	task wait_lvl(input int sel, input logic lvl, input int maxc);
		int   n;
		logic v;
		for (n = 0; n <= maxc; n++)
		begin
			@(posedge pclk);
			#1;
			v = (sel == 0) ? timer_a_running : (sel == 1) ? timer_b_running : timer_b_irq_flag;
			if (v === lvl)
				return;
		end
		fail_to("level wait");
	endtask : wait_lvl

	task pulse(input int s);
		@(posedge pclk);
		case (s)
			0:       tx_done <= 1'b1;
			1:       rx_first_bits <= 1'b1;
			default: third_timer_underflow <= 1'b1;
		endcase
		@(posedge pclk);
		tx_done               <= 1'b0;
		rx_first_bits         <= 1'b0;
		third_timer_underflow <= 1'b0;
	endtask : pulse

	// Low for two edges first, so the rise is always seen
	task trim_edge;
		@(posedge pclk);
		trim_ref <= 1'b0;
		repeat (2) @(posedge pclk);
		trim_ref <= 1'b1;
	endtask : trim_edge

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tx_done = 1'b0;
		rx_first_bits = 1'b0;
		trim_ref = 1'b0;
		third_timer_underflow = 1'b0;
		miscompares = 0;
		checks = 0;
		seed = 32'h8733cb2f;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_B_CONTROL);
		chk("b_control reset", 32'h0, rdv);
		repeat (6)
		begin
			wv = $random(seed);
			wr(IDX_B_CONTROL, wv);
			rd(IDX_B_CONTROL);
			chk("b_control", cexp(wv), rdv);
		end
		for (i = 0; i < 3; i++)
		begin
			wv = $random(seed);
			wr(IDX_A_RELOAD_HIGH + IDX_W'(i) * ((i == 2) ? 6'h05 : 6'h01) / ((i == 2) ? 6'h02 : 6'h01), wv);
			rd(IDX_A_RELOAD_HIGH + IDX_W'(i) * ((i == 2) ? 6'h05 : 6'h01) / ((i == 2) ? 6'h02 : 6'h01));
			chk("reload byte", {24'h000000, wv}, rdv);
		end
		a_hi = 8'h00;
		wr(IDX_A_RELOAD_HIGH, a_hi);
		apb(1'b0, 6'h3A, 8'h00, 2'b00);
		chk("pslverr unmapped", 32'h1, {31'h0, errv});
		apb(1'b1, IDX_A_RELOAD_HIGH, 8'hFF, 2'b10);
		chk("pslverr misaligned", 32'h1, {31'h0, errv});
		rd(IDX_A_RELOAD_HIGH);
		chk("reload kept", {24'h000000, a_hi}, rdv);
		// Run values without their mask bits must do nothing
		wr(IDX_GLOBAL_CTRL, 8'h30);
		repeat (3) @(posedge pclk);
		chk("a running masked", 32'h0, {31'h0, timer_a_running});
		chk("b running masked", 32'h0, {31'h0, timer_b_running});
		// One-shot, fast clock, random short reload
		wr(IDX_A_CONTROL, 8'h00);
		wv = ($random(seed) & 8'h0F) + 8'h02;
		wr(IDX_A_RELOAD_LOW, wv);
		wr(IDX_GLOBAL_CTRL, 8'h11);
		wait_lvl(0, 1'b1, 3);
		wait_lvl(0, 1'b0, tbound({8'h00, wv}, 1'b0));
		rd(IDX_A_COUNT_HIGH);
		chk("a count high", 32'h0, rdv);
		rd(IDX_A_COUNT_LOW);
		chk("a count low", 32'h0, rdv);
		rd(IDX_IRQ_STATUS);
		chk("irq a", 32'h1, rdv & 32'h1);
		// Reload rewritten mid-run must wait for the next start
		wr(IDX_A_RELOAD_HIGH, 8'h01);
		wr(IDX_A_RELOAD_LOW, 8'h00);
		wr(IDX_GLOBAL_CTRL, 8'h11);
		repeat (20) @(posedge pclk);
		wr(IDX_A_RELOAD_HIGH, 8'h00);
		wr(IDX_A_RELOAD_LOW, 8'h03);
		repeat (60) @(posedge pclk);
		chk("a still running", 32'h1, {31'h0, timer_a_running});
		wr(IDX_GLOBAL_CTRL, 8'h01);
		rd(IDX_A_COUNT_HIGH);
		cnt[15:8] = rdv[7:0];
		rd(IDX_A_COUNT_LOW);
		cnt[7:0] = rdv[7:0];
		chk("a count window", 32'h1, {31'h0, (cnt > 16'h00C0) && (cnt < 16'h0100)});
		rd(IDX_A_COUNT_LOW);
		chk("a count frozen", {24'h000000, cnt[7:0]}, rdv);
		wr(IDX_GLOBAL_CTRL, 8'h11);
		wait_lvl(0, 1'b1, 3);
		wait_lvl(0, 1'b0, tbound(16'h0003, 1'b0));
		// Second timer start sources
		wr(IDX_B_RELOAD_HIGH, 8'h00);
		wr(IDX_B_RELOAD_LOW, 8'h02);
		wr(IDX_B_CONTROL, 8'h01);
		pulse(0);
		repeat (3) @(posedge pclk);
		chk("b host-only", 32'h0, {31'h0, timer_b_running});
		wr(IDX_B_CONTROL, 8'h11);
		pulse(0);
		wait_lvl(1, 1'b1, 3);
		repeat (200) @(posedge pclk);
		chk("b slow clock", 32'h1, {31'h0, timer_b_running});
		pulse(1);
		repeat (3) @(posedge pclk);
		chk("b rx ignored", 32'h1, {31'h0, timer_b_running});
		wr(IDX_B_CONTROL, 8'h91);
		pulse(1);
		wait_lvl(1, 1'b0, 3);
		// Trimming without underflow: holds at zero, stop bit ignored
		wr(IDX_B_CONTROL, 8'hA0);
		wr(IDX_IRQ_STATUS, 8'h03);
		trim_edge();
		wait_lvl(1, 1'b1, 4);
		repeat (100) @(posedge pclk);
		chk("b trim running", 32'h1, {31'h0, timer_b_running});
		chk("b trim no irq", 32'h0, {31'h0, timer_b_irq_flag});
		pulse(1);
		repeat (3) @(posedge pclk);
		chk("b trim rx", 32'h1, {31'h0, timer_b_running});
		trim_edge();
		wait_lvl(1, 1'b0, 4);
		// Trimming with underflow
		wr(IDX_B_CONTROL, 8'h30);
		trim_edge();
		wait_lvl(1, 1'b1, 4);
		wait_lvl(1, 1'b0, tbound(16'h0002, 1'b0));
		// Flag follows the stop by one cycle
		repeat (2) @(posedge pclk);
		chk("b irq trim", 32'h1, {31'h0, timer_b_irq_flag});
		// Auto-restart keeps it going past zero
		wr(IDX_B_CONTROL, 8'h08);
		wr(IDX_IRQ_STATUS, 8'h03);
		chk("b irq cleared", 32'h0, {31'h0, timer_b_irq_flag});
		wr(IDX_GLOBAL_CTRL, 8'h22);
		repeat (150) @(posedge pclk);
		chk("b auto running", 32'h1, {31'h0, timer_b_running});
		chk("b auto irq", 32'h1, {31'h0, timer_b_irq_flag});
		wr(IDX_GLOBAL_CTRL, 8'h02);
		wait_lvl(1, 1'b0, 3);
		// Cascade from the external third timer
		wr(IDX_B_CONTROL, 8'h03);
		wr(IDX_B_RELOAD_LOW, 8'h01);
		wr(IDX_IRQ_STATUS, 8'h03);
		wr(IDX_GLOBAL_CTRL, 8'h22);
		repeat (100) @(posedge pclk);
		chk("b cascade idle", 32'h1, {31'h0, timer_b_running});
		pulse(2);
		repeat (3) @(posedge pclk);
		chk("b after one", 32'h1, {31'h0, timer_b_running});
		pulse(2);
		wait_lvl(1, 1'b0, 4);
		chk("b cascade irq", 32'h1, {31'h0, timer_b_irq_flag});
		// Cascade from the first timer's underflow
		wr(IDX_B_CONTROL, 8'h02);
		wr(IDX_A_CONTROL, 8'h08);
		wr(IDX_A_RELOAD_LOW, 8'h02);
		wr(IDX_IRQ_STATUS, 8'h03);
		wr(IDX_GLOBAL_CTRL, 8'h33);
		wait_lvl(2, 1'b1, 3 * tbound(16'h0002, 1'b0));
		wr(IDX_GLOBAL_CTRL, 8'h03);
		// First timer counts third-timer underflows
		wr(IDX_A_CONTROL, 8'h02);
		wr(IDX_A_RELOAD_LOW, 8'h01);
		wr(IDX_GLOBAL_CTRL, 8'h11);
		pulse(2);
		repeat (3) @(posedge pclk);
		chk("a cascade one", 32'h1, {31'h0, timer_a_running});
		pulse(2);
		wait_lvl(0, 1'b0, 4);
		give_verdict();
	end
endmodule : rfct_timers_test
